// ### hw/blb_exec.sv
// execution unit for and-test, and-not clear and the relative branch group
// assumes operands are fetched elsewhere; start is a one-cycle pulse on clk
//
// Notes on behaviour
// - clear: byte bit, source, destination fields
// - and-test only sets flags, no writeback
// - N from top result bit, Z on zero
// - logic ops clear V, keep C
// - clear writes destination AND NOT source
// - taken branch adds twice the offset
// - target based on already-advanced PC
// - offset bits 7:0, sign-extended from bit 7
// - conditional loads target only when true
// - branches never touch condition flags
// - always-branch always loads target
// - unequal branch taken when Z clear
// - minus branch, prefix 1004, N set
// - plus branch taken when N clear
// - branch lasts 1.5 us or 2.6 us
`timescale 1ns/1ps
`default_nettype none
`include "blb_consts.svh"
module blb_exec
  import blb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request
  input wire logic start,
  input wire logic [15:0] instr,
  input wire logic [15:0] src_val,
  input wire logic [15:0] dst_val,
  input wire logic [15:0] pc_val,
  // condition codes written by other instructions
  input wire logic cc_load,
  input wire logic [3:0] cc_in,
  // answer
  output logic busy_ff,
  output logic done_ff,
  output logic unknown_ff,
  output logic wr_en_ff,
  output logic wr_byte_ff,
  output logic [15:0] result_ff,
  output logic pc_load_ff,
  output logic [15:0] pc_out_ff,
  // condition codes
  output logic n_ff,
  output logic z_ff,
  output logic v_ff,
  output logic c_ff
);
  // ==========================================================
  // decode
  op_if d ();
  assign d.instr = instr;
  blb_decode u_decode (.d(d));

  // ==========================================================
  // datapath
  logic is_logic, is_branch, cond_ok, accept;
  logic [15:0] logic_res, target;
  logic [15:0] res_masked;
  logic lres_n, lres_z;

  assign is_logic = (d.kind == K_TEST) || (d.kind == K_CLEAR);
  assign is_branch = (d.kind == K_ALWAYS) || (d.kind == K_EQUAL) || (d.kind == K_UNEQUAL)
                     || (d.kind == K_MINUS) || (d.kind == K_PLUS);

  always_comb begin
    logic_res = (d.kind == K_CLEAR) ? (dst_val & ~src_val) : (dst_val & src_val);
    // high byte of the destination kept in byte form
    res_masked = d.is_byte ? {dst_val[15:8], logic_res[7:0]} : logic_res;
    lres_n = d.is_byte ? logic_res[7] : logic_res[15];
    lres_z = d.is_byte ? (logic_res[7:0] == 8'h00) : (logic_res == 16'h0000);
  end

  // offset doubled, sign from bit 7, advanced PC
  assign target = pc_val + {{7{d.offset[`OFS_SIGN]}}, d.offset, 1'b0};

  // flags read at the start edge; a later side load cannot flip the decision
  always_comb begin
    case (d.kind)
      K_ALWAYS: cond_ok = 1'b1;
      K_EQUAL: cond_ok = z_ff;
      K_UNEQUAL: cond_ok = ~z_ff;
      K_MINUS: cond_ok = n_ff;
      K_PLUS: cond_ok = ~n_ff;
      default: cond_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // sequencer
  state_t state_ff, nxt_state;
  logic [`CNT_W-1:0] cnt_ff, nxt_cnt;
  logic nxt_done, nxt_unknown, nxt_wr_en, nxt_wr_byte, nxt_pc_load, nxt_busy;
  logic [15:0] nxt_result, nxt_pc_out;
  logic hold_take_ff, nxt_hold_take;
  logic [15:0] hold_pc_ff, nxt_hold_pc;
  logic nxt_n, nxt_z, nxt_v, nxt_c;

  // starts while busy are dropped, so a branch always keeps its full length
  assign accept = start && (state_ff == S_IDLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_unknown = 1'b0;
    nxt_wr_en = 1'b0;
    nxt_wr_byte = wr_byte_ff;
    nxt_result = result_ff;
    nxt_pc_load = 1'b0;
    nxt_pc_out = pc_out_ff;
    nxt_hold_take = hold_take_ff;
    nxt_hold_pc = hold_pc_ff;
    nxt_n = n_ff;
    nxt_z = z_ff;
    nxt_v = v_ff;
    nxt_c = c_ff;
    // flags from other instructions only while this unit is not updating them
    if (cc_load && !(accept && is_logic)) begin
      {nxt_n, nxt_z, nxt_v, nxt_c} = cc_in;
    end
    case (state_ff)
      S_IDLE: begin
        if (accept && is_logic) begin
          nxt_done = 1'b1;
          nxt_wr_en = (d.kind == K_CLEAR);
          nxt_wr_byte = d.is_byte;
          nxt_result = res_masked;
          nxt_n = lres_n;
          nxt_z = lres_z;
          nxt_v = 1'b0;
          nxt_c = c_ff;
        end else if (accept && is_branch) begin
          // length fixed by the outcome; the load comes at the end
          nxt_state = S_BUSY;
          nxt_hold_take = cond_ok;
          // not-taken path keeps the advanced PC
          nxt_hold_pc = cond_ok ? target : pc_val;
          nxt_cnt = cond_ok ? `CNT_W'(`CYC_JUMP_TAKEN - 2) : `CNT_W'(`CYC_JUMP_NOTAKEN - 2);
        end else if (accept) begin
          nxt_done = 1'b1;
          nxt_unknown = 1'b1;
        end
      end
      S_BUSY: begin
        // the pc is handed over once, with the done pulse, never mid-wait
        if (cnt_ff == `CNT_W'(0)) begin
          nxt_state = S_IDLE;
          nxt_done = 1'b1;
          nxt_pc_load = hold_take_ff;
          nxt_pc_out = hold_pc_ff;
        end else begin
          nxt_cnt = cnt_ff - `CNT_W'(1);
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    nxt_busy = (nxt_state == S_BUSY);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= S_IDLE;
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      unknown_ff <= 1'b0;
      wr_en_ff <= 1'b0;
      wr_byte_ff <= 1'b0;
      result_ff <= 16'h0000;
      pc_load_ff <= 1'b0;
      pc_out_ff <= `PC_RESET;
      hold_take_ff <= 1'b0;
      hold_pc_ff <= `PC_RESET;
      {n_ff, z_ff, v_ff, c_ff} <= `CC_RESET;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      unknown_ff <= nxt_unknown;
      wr_en_ff <= nxt_wr_en;
      wr_byte_ff <= nxt_wr_byte;
      result_ff <= nxt_result;
      pc_load_ff <= nxt_pc_load;
      pc_out_ff <= nxt_pc_out;
      hold_take_ff <= nxt_hold_take;
      hold_pc_ff <= nxt_hold_pc;
      n_ff <= nxt_n;
      z_ff <= nxt_z;
      v_ff <= nxt_v;
      c_ff <= nxt_c;
    end
  end

  // ==========================================================
  // checks
  // helper: cycles since a branch was accepted
  logic [`CNT_W-1:0] el_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      el_ff <= '0;
    end else if (accept) begin
      el_ff <= `CNT_W'(1);
    end else if (state_ff == S_BUSY) begin
      el_ff <= el_ff + `CNT_W'(1);
    end
  end

  sequence s_logic_go;
    accept && is_logic;
  endsequence
  sequence s_branch_go;
    accept && is_branch && !cc_load;
  endsequence
  // last cycle of a branch: the done pulse right after the busy phase
  sequence s_branch_end;
    done_ff && $past(state_ff) == S_BUSY;
  endsequence

  // ==========================================================
  // logic operations and unknown words
  a_clear_result: assert property (@(posedge clk) disable iff (reset)
    accept && d.kind == K_CLEAR && !d.is_byte |=> wr_en_ff
      && result_ff == ($past(dst_val) & ~$past(src_val)))
    else $error("clear result or write wrong");
  a_test_no_write: assert property (@(posedge clk) disable iff (reset)
    accept && d.kind == K_TEST |=> done_ff && !wr_en_ff)
    else $error("and-test wrote back");
  a_logic_nz: assert property (@(posedge clk) disable iff (reset)
    s_logic_go |=> n_ff == ($past(d.is_byte) ? $past(logic_res[7]) : $past(logic_res[15]))
      && z_ff == ($past(d.is_byte) ? ($past(logic_res[7:0]) == 8'h00) :
      ($past(logic_res) == 16'h0000)))
    else $error("logic N or Z wrong");
  a_logic_vc: assert property (@(posedge clk) disable iff (reset)
    s_logic_go |=> !v_ff && c_ff == $past(c_ff))
    else $error("logic V or C wrong");
  a_byte_lane: assert property (@(posedge clk) disable iff (reset)
    s_logic_go ##0 d.is_byte |=> wr_byte_ff && result_ff[15:8] == $past(dst_val[15:8]))
    else $error("byte form touched high byte");
  a_logic_done: assert property (@(posedge clk) disable iff (reset)
    s_logic_go |=> done_ff && !busy_ff && !pc_load_ff && !unknown_ff)
    else $error("logic op did not finish alone");
  a_field_split: assert property (@(posedge clk) disable iff (reset)
    s_logic_go |-> d.src_spec == instr[`SRC_HI:`SRC_LO]
      && d.dst_spec == instr[`DST_HI:`DST_LO])
    else $error("operand fields split wrong");
  a_unknown_quiet: assert property (@(posedge clk) disable iff (reset)
    accept && d.kind == K_NONE |=> done_ff && unknown_ff && !wr_en_ff
      && !pc_load_ff && !busy_ff)
    else $error("unknown word had side effects");

  // ==========================================================
  // branches
  a_branch_cc_hold: assert property (@(posedge clk) disable iff (reset)
    s_branch_go ##1 !cc_load [*8] |-> $stable({n_ff, z_ff, v_ff, c_ff}))
    else $error("branch changed flags");
  a_branch_cond: assert property (@(posedge clk) disable iff (reset)
    s_branch_go |=> hold_take_ff == $past(cond_ok) && hold_pc_ff == ($past(cond_ok) ?
      $past(pc_val) + {{7{$past(instr[7])}}, $past(instr[7:0]), 1'b0} : $past(pc_val)))
    else $error("branch decision or target wrong");
  a_branch_time: assert property (@(posedge clk) disable iff (reset)
    s_branch_end |-> el_ff == (pc_load_ff ?
      `CNT_W'(`CYC_JUMP_TAKEN) : `CNT_W'(`CYC_JUMP_NOTAKEN)))
    else $error("branch duration wrong");
  a_branch_load: assert property (@(posedge clk) disable iff (reset)
    accept && d.kind == K_ALWAYS |=> busy_ff && hold_take_ff)
    else $error("always-branch not taken");
  // the decision reads the flags as they stood on the start edge
  a_equal_cond: assert property (@(posedge clk) disable iff (reset)
    accept && d.kind == K_EQUAL |=> busy_ff && hold_take_ff == $past(z_ff))
    else $error("equal branch decision wrong");
  a_unequal_cond: assert property (@(posedge clk) disable iff (reset)
    accept && d.kind == K_UNEQUAL |=> busy_ff && hold_take_ff == !$past(z_ff))
    else $error("unequal branch decision wrong");
  a_minus_cond: assert property (@(posedge clk) disable iff (reset)
    accept && d.kind == K_MINUS |=> busy_ff && hold_take_ff == $past(n_ff))
    else $error("minus branch decision wrong");
  a_plus_cond: assert property (@(posedge clk) disable iff (reset)
    accept && d.kind == K_PLUS |=> busy_ff && hold_take_ff == !$past(n_ff))
    else $error("plus branch decision wrong");
  // a start while busy is dropped, so length and target stay put
  a_busy_refuse: assert property (@(posedge clk) disable iff (reset)
    start && busy_ff |=> $stable(hold_pc_ff) && $stable(hold_take_ff))
    else $error("start accepted while busy");
  a_busy_span: assert property (@(posedge clk) disable iff (reset)
    accept && is_branch |=> busy_ff [*8])
    else $error("branch ended too early");
  a_end_transfer: assert property (@(posedge clk) disable iff (reset)
    s_branch_end |-> pc_load_ff == hold_take_ff && pc_out_ff == hold_pc_ff)
    else $error("branch end lost target or decision");
  a_branch_end_flags: assert property (@(posedge clk) disable iff (reset)
    s_branch_end ##0 !$past(cc_load) |-> $stable({n_ff, z_ff, v_ff, c_ff}))
    else $error("branch end changed flags");
endmodule : blb_exec
`default_nettype wire

// ### common/blb_consts.svh
// constants for the bitwise-test, bit-clear and relative-branch execution unit
// assumes a 200 MHz core clock; included by bare name
`ifndef BLB_CONSTS_SVH
`define BLB_CONSTS_SVH

// clock
`define CLK_PERIOD_NS 5
// instruction fields
`define BYTE_BIT 15
`define OPC_HI 14
`define OPC_LO 12
`define SRC_HI 11
`define SRC_LO 6
`define DST_HI 5
`define DST_LO 0
`define JUMP_CODE_HI 15
`define JUMP_CODE_LO 8
`define OFS_SIGN 7
// double-operand codes in bits 14:12
`define OPC_AND_TEST 3'h3
`define OPC_AND_NOT 3'h4
// branch codes in bits 15:8
`define BRC_ALWAYS 8'h01
`define BRC_UNEQUAL 8'h02
`define BRC_EQUAL 8'h03
`define BRC_PLUS 8'h80
`define BRC_MINUS 8'h81
// branch timing in ns: 1.5 us not taken, 2.6 us taken
`define T_JUMP_NOTAKEN_NS 1500
`define T_JUMP_TAKEN_NS 2600
`define CYC_JUMP_NOTAKEN ((`T_JUMP_NOTAKEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_JUMP_TAKEN ((`T_JUMP_TAKEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 10
// reset values
`define PC_RESET 16'h0000
`define CC_RESET 4'h0

`endif

// ### common/blb_pkg.sv
// types shared by the execution unit and its decoder
// assumes nothing beyond a SystemVerilog compiler
package blb_pkg;
  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_TEST = 4'h1,
    K_CLEAR = 4'h2,
    K_ALWAYS = 4'h3,
    K_EQUAL = 4'h4,
    K_UNEQUAL = 4'h5,
    K_MINUS = 4'h6,
    K_PLUS = 4'h7
  } op_kind_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_BUSY = 2'b10
  } state_t;
endpackage : blb_pkg

// ### common/op_if.sv
// decoded instruction fields passed from the decoder to the execution unit
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`default_nettype none
interface op_if;
  import blb_pkg::*;
  logic [15:0] instr;
  op_kind_t kind;
  logic is_byte;
  logic [5:0] src_spec;
  logic [5:0] dst_spec;
  logic [7:0] offset;
  modport decoder (input instr, output kind, is_byte, src_spec, dst_spec, offset);
  modport exe (output instr, input kind, is_byte, src_spec, dst_spec, offset);
endinterface : op_if
`default_nettype wire

// ### hw/blb_decode.sv
// instruction decoder: classifies the instruction word and splits its fields
// assumes the word is stable while the execution unit samples the result
`timescale 1ns/1ps
`default_nettype none
`include "blb_consts.svh"
module blb_decode
  import blb_pkg::*;
(
  op_if.decoder d
);
  logic [7:0] jump_code;

  assign jump_code = d.instr[`JUMP_CODE_HI:`JUMP_CODE_LO];
  assign d.src_spec = d.instr[`SRC_HI:`SRC_LO];
  assign d.dst_spec = d.instr[`DST_HI:`DST_LO];
  assign d.offset = d.instr[7:0];

  always_comb begin
    d.kind = K_NONE;
    d.is_byte = 1'b0;
    if (d.instr[`OPC_HI:`OPC_LO] == `OPC_AND_NOT) begin
      d.kind = K_CLEAR;
      d.is_byte = d.instr[`BYTE_BIT];
    end else if (d.instr[`OPC_HI:`OPC_LO] == `OPC_AND_TEST) begin
      d.kind = K_TEST;
      d.is_byte = d.instr[`BYTE_BIT];
    end else begin
      case (jump_code)
        `BRC_ALWAYS: d.kind = K_ALWAYS;
        `BRC_UNEQUAL: d.kind = K_UNEQUAL;
        `BRC_EQUAL: d.kind = K_EQUAL;
        `BRC_PLUS: d.kind = K_PLUS;
        `BRC_MINUS: d.kind = K_MINUS;
        default: d.kind = K_NONE;
      endcase
    end
  end
endmodule : blb_decode
`default_nettype wire

// ### tb/tb_bit_logic_and_branch_unit.sv
// self-checking bench for the and-test, and-not clear and relative-branch unit
// assumes blb_exec, blb_pkg and blb_consts.svh compiled alongside; 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "blb_consts.svh"
module tb_bit_logic_and_branch_unit;
  import blb_pkg::*;
  typedef struct {
    logic [23:0] exp;
    logic [23:0] mask;
    logic is_jump;
    int at;
  } note_t;
  // ==========================================================
  // signals
  logic clk, reset, start, cc_load;
  logic [15:0] instr, src_val, dst_val, pc_val, result_ff, pc_out_ff;
  logic [3:0] cc_in, cc_model;
  logic busy_ff, done_ff, unknown_ff, wr_en_ff, wr_byte_ff, pc_load_ff;
  logic n_ff, z_ff, v_ff, c_ff;
  logic [23:0] got;
  logic [7:0] codes [5];
  note_t notes [$];
  note_t mon_nt;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 19357;
  logic [15:0] s, d;

  blb_exec uut (.clk(clk), .reset(reset), .start(start), .instr(instr), .src_val(src_val),
    .dst_val(dst_val), .pc_val(pc_val), .cc_load(cc_load), .cc_in(cc_in), .busy_ff(busy_ff),
    .done_ff(done_ff), .unknown_ff(unknown_ff), .wr_en_ff(wr_en_ff), .wr_byte_ff(wr_byte_ff),
    .result_ff(result_ff), .pc_load_ff(pc_load_ff), .pc_out_ff(pc_out_ff), .n_ff(n_ff),
    .z_ff(z_ff), .v_ff(v_ff), .c_ff(c_ff));

  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #(`CLK_PERIOD_NS / 2.0) clk = ~clk;
  end

  // ten branches of at most 520 cycles plus short ops stay far below this
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // flags load through the side port; start is kept low so the load is not overridden
  task automatic set_cc(input logic [3:0] v);
    @(negedge clk);
    start = 1'b0;
    cc_load = 1'b1;
    cc_in = v;
    cc_model = v;
    @(negedge clk);
    cc_load = 1'b0;
  endtask : set_cc

  task automatic logic_op(input logic bf, input logic clr, input logic [15:0] sv, dv);
    note_t nt;
    logic [15:0] r;
    logic n, z;
    @(negedge clk);
    start = 1'b1;
    instr = {bf, (clr ? `OPC_AND_NOT : `OPC_AND_TEST), 12'($random(seed))};
    src_val = sv;
    dst_val = dv;
    r = clr ? (dv & ~sv) : (dv & sv);
    if (bf) r[15:8] = dv[15:8];
    n = bf ? r[7] : r[15];
    z = bf ? (r[7:0] == 8'h00) : (r == 16'h0000);
    nt.exp = {1'b0, clr, bf, 1'b0, r, n, z, 1'b0, cc_model[0]};
    nt.mask = clr ? 24'hFFFFFF : 24'hF0000F;
    nt.is_jump = 1'b0;
    nt.at = cyc + 1;
    cc_model = {n, z, 1'b0, cc_model[0]};
    notes.push_back(nt);
  endtask : logic_op

  task automatic branch(input logic [7:0] code, input logic [7:0] ofs, input logic poke);
    note_t nt;
    logic tk;
    logic [15:0] pc;
    pc = 16'($random(seed)) & 16'hFFFE;
    case (code)
      `BRC_ALWAYS: tk = 1'b1;
      `BRC_UNEQUAL: tk = !cc_model[2];
      `BRC_EQUAL: tk = cc_model[2];
      `BRC_PLUS: tk = !cc_model[3];
      default: tk = cc_model[3];
    endcase
    @(negedge clk);
    start = 1'b1;
    instr = {code, ofs};
    pc_val = pc;
    nt.exp = {3'b000, tk, (tk ? pc + {{7{ofs[7]}}, ofs, 1'b0} : pc), cc_model};
    nt.mask = 24'hDFFFFF;
    nt.is_jump = 1'b1;
    nt.at = cyc + (tk ? `CYC_JUMP_TAKEN : `CYC_JUMP_NOTAKEN);
    notes.push_back(nt);
    @(negedge clk);
    start = poke;
    instr = 16'h4000;
    @(negedge clk);
    start = 1'b0;
    check({31'h0, busy_ff}, 32'h1);
    for (int k = 0; k < 600 && done_ff !== 1'b1; k++) @(negedge clk);
  endtask : branch

  task automatic odd_op(input logic [15:0] w);
    note_t nt;
    @(negedge clk);
    start = 1'b1;
    instr = w;
    nt.exp = {4'h8, 16'h0000, cc_model};
    nt.mask = 24'hD0000F;
    nt.is_jump = 1'b0;
    nt.at = cyc + 1;
    notes.push_back(nt);
    @(negedge clk);
    start = 1'b0;
  endtask : odd_op

  // ==========================================================
  // result watcher: oldest note against each finished instruction
  always @(negedge clk) begin
    if (reset === 1'b0 && done_ff === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        mon_nt = notes.pop_front();
        got = {unknown_ff, wr_en_ff, wr_byte_ff, pc_load_ff,
          (mon_nt.is_jump ? pc_out_ff : result_ff), n_ff, z_ff, v_ff, c_ff};
        check({8'h0, got & mon_nt.mask}, {8'h0, mon_nt.exp & mon_nt.mask});
        check(cyc, mon_nt.at);
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    start = 1'b0;
    cc_load = 1'b0;
    cc_in = 4'h0;
    instr = 16'h0000;
    src_val = 16'h0000;
    dst_val = 16'h0000;
    pc_val = 16'h0000;
    cc_model = `CC_RESET;
    codes = '{`BRC_ALWAYS, `BRC_UNEQUAL, `BRC_EQUAL, `BRC_PLUS, `BRC_MINUS};
    repeat (8) @(negedge clk);
    reset = 1'b0;
    check({26'h0, busy_ff, done_ff, unknown_ff, wr_en_ff, wr_byte_ff, pc_load_ff}, 32'h0);
    check({28'h0, n_ff, z_ff, v_ff, c_ff}, 32'h0);
    check({result_ff, pc_out_ff}, 32'h0);
    // flags all clear then all set, so each condition except always is both met and missed
    for (int i = 0; i < 10; i++) begin
      set_cc(i < 5 ? 4'h0 : 4'hF);
      branch(codes[i % 5], (i % 2 == 1) ? 8'h7F : 8'h80, i == 3);
    end
    for (int i = 0; i < 40; i++) begin
      if (i % 8 == 0) set_cc(4'($random(seed)));
      s = 16'($random(seed));
      d = (i % 4 == 0) ? ~s : ((i % 4 == 3) ? s : 16'($random(seed)));
      logic_op(i[0], i[1], s, d);
    end
    odd_op(16'h0400);
    odd_op(16'h2000);
    repeat (4) @(negedge clk);
    check(notes.size(), 32'h0);
    report_and_stop();
  end
endmodule : tb_bit_logic_and_branch_unit
`default_nettype wire
